// ### verilog/debi_defines.svh
`ifndef DEBI_DEFINES_SVH
`define DEBI_DEFINES_SVH

// Register byte addresses
`define DEBI_EXP_CTL_ADDR   32'h00808060
`define DEBI_PRI_CTL_ADDR   32'h00808064

// Field positions
`define DEBI_HOLDST_BIT     0
`define DEBI_IGNREQ_BIT     1
`define DEBI_SWREL_BIT      2
`define DEBI_MODE_LSB       3
`define DEBI_MODE_MSB       4
`define DEBI_CNT_LSB        5
`define DEBI_CNT_MSB        7
`define DEBI_BANK_LSB       8
`define DEBI_BANK_MSB       12

// Reset values
`define DEBI_MODE_RST       2'h3
`define DEBI_CNT_RST        3'h7
`define DEBI_BANK_RST       5'h10

// Bank compare limit and wait modes
`define DEBI_BANK_MAX       5'h10
`define DEBI_MODE_EXT       2'h0
`define DEBI_MODE_CNT       2'h1
`define DEBI_MODE_ANY       2'h2
`define DEBI_MODE_ALL       2'h3

`endif

// ### verilog/debi_pkg.sv
package debi_pkg;

	typedef enum logic [2:0] {
		PS_IDLE, PS_BANK, PS_RACT, PS_WTURN, PS_WACT, PS_WPOST, PS_HOLD
	} debi_pri_st_t;

	typedef enum logic [2:0] {
		XS_IDLE, XS_RACT, XS_WTURN, XS_WACT, XS_WPOST, XS_IOSET, XS_IOACT
	} debi_exp_st_t;

endpackage : debi_pkg

// ### verilog/debi_ifs.sv
`timescale 1ns/10ps

interface debi_cfg_if;
	logic [1:0] pri_mode;
	logic [2:0] pri_cnt;
	logic [4:0] bank_cmp;
	logic       ignore_release_request;
	logic       software_bus_release;
	logic [1:0] exp_mode;
	logic [2:0] exp_cnt;
	logic       hold_status;
	modport regs (output pri_mode, pri_cnt, bank_cmp, ignore_release_request, software_bus_release,
		exp_mode, exp_cnt, input hold_status);
	modport core (input pri_mode, pri_cnt, bank_cmp, ignore_release_request, software_bus_release,
		exp_mode, exp_cnt, output hold_status);
endinterface : debi_cfg_if

interface debi_wait_if;
	logic       busy;
	logic [1:0] mode;
	logic [2:0] count;
	logic       ext_rdy_n;
	logic       int_rdy_n;
	modport gen (input busy, mode, count, ext_rdy_n, output int_rdy_n);
	modport seq (output busy, mode, count, ext_rdy_n, input int_rdy_n);
endinterface : debi_wait_if

// ### verilog/debi_wait_gen.sv
`timescale 1ns/10ps
`include "debi_defines.svh"

module debi_wait_gen (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Sequencer side
	debi_wait_if.gen  w
);

	logic [2:0] cnt;
	logic       counter_ready_n;

	// Preloaded while no access runs, so the first active cycle sees the count
	// Also reloaded as an access completes, since a back-to-back read never leaves busy
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt <= 3'h0;
		else if (!w.busy || !w.int_rdy_n)
			cnt <= w.count;
		else if (cnt != 3'h0)
			cnt <= cnt - 3'h1;
	end

	assign counter_ready_n = (cnt != 3'h0);

	always_comb
	begin
		case (w.mode)
			`DEBI_MODE_EXT: w.int_rdy_n = w.ext_rdy_n;
			`DEBI_MODE_CNT: w.int_rdy_n = counter_ready_n;
			`DEBI_MODE_ANY: w.int_rdy_n = w.ext_rdy_n & counter_ready_n;
			default:        w.int_rdy_n = w.ext_rdy_n | counter_ready_n;
		endcase
	end

	cnt_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(w.busy && !$past(w.busy)) |-> cnt == $past(w.count))
		else $error("wait counter not loaded at access start");
	cnt_ready_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(w.mode == `DEBI_MODE_CNT && w.busy && cnt == 3'h0) |-> !w.int_rdy_n)
		else $error("counter mode did not complete at zero");
	cnt_reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(w.busy && !w.int_rdy_n) |=> cnt == $past(w.count))
		else $error("wait counter not reloaded at access end");

endmodule : debi_wait_gen

// ### verilog/debi_ahb_regs.sv
`timescale 1ns/10ps
`include "debi_defines.svh"

module debi_ahb_regs (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Configuration
	debi_cfg_if.regs         c
);

	logic        wr_pend;
	logic        rd_pend;
	logic [31:0] acc_addr;
	logic [31:0] rd_word;

	// Reads take one wait so a preceding write is always visible
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend   <= 1'b0;
			rd_pend   <= 1'b0;
			acc_addr  <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0;
		end
		else
		begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			hresp   <= 1'b0;
			if (rd_pend)
			begin
				hrdata    <= rd_word;
				hreadyout <= 1'b1;
			end
			else if (hready && hsel && htrans[1])
			begin
				acc_addr <= haddr;
				wr_pend  <= hwrite;
				rd_pend  <= !hwrite;
				if (!hwrite)
					hreadyout <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			c.pri_mode               <= `DEBI_MODE_RST;
			c.pri_cnt                <= `DEBI_CNT_RST;
			c.bank_cmp               <= `DEBI_BANK_RST;
			c.ignore_release_request <= 1'b0;
			c.software_bus_release   <= 1'b0;
			c.exp_mode               <= `DEBI_MODE_RST;
			c.exp_cnt                <= `DEBI_CNT_RST;
		end
		else if (wr_pend && acc_addr == `DEBI_PRI_CTL_ADDR)
		begin
			c.pri_mode               <= hwdata[`DEBI_MODE_MSB:`DEBI_MODE_LSB];
			c.pri_cnt                <= hwdata[`DEBI_CNT_MSB:`DEBI_CNT_LSB];
			c.bank_cmp               <= hwdata[`DEBI_BANK_MSB:`DEBI_BANK_LSB];
			c.ignore_release_request <= hwdata[`DEBI_IGNREQ_BIT];
			c.software_bus_release   <= hwdata[`DEBI_SWREL_BIT];
		end
		else if (wr_pend && acc_addr == `DEBI_EXP_CTL_ADDR)
		begin
			c.exp_mode <= hwdata[`DEBI_MODE_MSB:`DEBI_MODE_LSB];
			c.exp_cnt  <= hwdata[`DEBI_CNT_MSB:`DEBI_CNT_LSB];
		end
	end

	always_comb
	begin
		rd_word = 32'h0;
		if (acc_addr == `DEBI_PRI_CTL_ADDR)
		begin
			rd_word[`DEBI_HOLDST_BIT]                = c.hold_status;
			rd_word[`DEBI_IGNREQ_BIT]                = c.ignore_release_request;
			rd_word[`DEBI_SWREL_BIT]                 = c.software_bus_release;
			rd_word[`DEBI_MODE_MSB:`DEBI_MODE_LSB]   = c.pri_mode;
			rd_word[`DEBI_CNT_MSB:`DEBI_CNT_LSB]     = c.pri_cnt;
			rd_word[`DEBI_BANK_MSB:`DEBI_BANK_LSB]   = c.bank_cmp;
		end
		else if (acc_addr == `DEBI_EXP_CTL_ADDR)
		begin
			rd_word[`DEBI_MODE_MSB:`DEBI_MODE_LSB]   = c.exp_mode;
			rd_word[`DEBI_CNT_MSB:`DEBI_CNT_LSB]     = c.exp_cnt;
		end
	end

endmodule : debi_ahb_regs

// ### verilog/debi_top.sv
// Notes on behaviour
// - Three exclusive spaces, one low strobe each
// - Primary and expansion buses run independently
// - Every bus cycle is whole clock cycles
// - Read one cycle, write two, three after read
// - Write accepted in one cycle when idle
// - Strobe low one cycle; writes framed by transitions
// - Direction and address change in transition cycles
// - Direction never changes while strobe is low
// - High external ready holds access one more cycle
// - I/O accesses take two cycles, strobe inside
// - I/O strobe high between cycles; direction per access
// - I/O address frames the I/O strobe
// - I/O wait extends strobe, direction, address, data
// - Idle bus drives strobes and direction high
// - Release request granted low, pins floated on the same edge
// - Access in progress finishes before release grant
// - Internal ready stretches or completes each access
// - Wait count loads, counts down, holds zero
// - Wait mode selects external, counter, either, both
// - Bank idle cycles on primary bus only
// - Bank compare picks top address bits, max sixteen
// - Last primary bank bits kept, cleared at reset
// - Bank change on read inserts one idle cycle
// - Wait mode and count fields with resets
// - Bank compare field, reset sixteen
// - Ignore-release bit blocks external release
// - Software release bit floats primary port
`timescale 1ns/10ps
`include "debi_defines.svh"

module debi_top (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite register port
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Primary requester
	input  wire logic        pri_req,
	input  wire logic        pri_we,
	input  wire logic [23:0] pri_addr,
	input  wire logic [31:0] pri_wdata,
	output logic             pri_ack,
	output logic             pri_rvalid,
	output logic [31:0]      pri_rdata,
	// Expansion requester
	input  wire logic        exp_req,
	input  wire logic        exp_we,
	input  wire logic        exp_io,
	input  wire logic [12:0] exp_addr,
	input  wire logic [31:0] exp_wdata,
	output logic             exp_ack,
	output logic             exp_rvalid,
	output logic [31:0]      exp_rdata,
	// Primary bus pins
	output logic             primary_access_strobe_n,
	output logic             pri_rnw,
	output logic [23:0]      pri_addr_o,
	output logic             pri_ctl_oe,
	output logic [31:0]      pri_data_o,
	output logic             pri_data_oe,
	input  wire logic [31:0] pri_data_i,
	input  wire logic        pri_rdy_n,
	input  wire logic        hold_req_n,
	output logic             bus_release_grant_n,
	// Expansion bus pins
	output logic             expansion_memory_strobe_n,
	output logic             expansion_io_strobe_n,
	output logic             expansion_read_not_write,
	output logic [12:0]      expansion_address_bus,
	output logic [31:0]      exp_data_o,
	output logic             exp_data_oe,
	input  wire logic [31:0] exp_data_i,
	input  wire logic        expansion_ready_input_n
);

	debi_cfg_if  cfg ();
	debi_wait_if pw ();
	debi_wait_if xw ();

	debi_pkg::debi_pri_st_t pri_st;
	debi_pkg::debi_exp_st_t exp_st;

	logic        hold_meta;
	logic        hold_sync;
	logic        hold_want;
	logic [23:0] bank_bits;
	logic [23:0] mask;
	logic        bank_switch;
	logic        pri_take;
	logic        exp_take;

	// Reserved compare values fall back to sixteen bits
	function automatic logic [23:0] bank_mask(input logic [4:0] n);
		logic [4:0] k;
		k = (n > `DEBI_BANK_MAX) ? `DEBI_BANK_MAX : n;
		bank_mask = ~(24'hFFFFFF >> k);
	endfunction : bank_mask

	debi_ahb_regs u_regs (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.c         (cfg.regs)
	);

	debi_wait_gen u_pri_wait (
		.hclk    (hclk),
		.hresetn (hresetn),
		.w       (pw.gen)
	);

	debi_wait_gen u_exp_wait (
		.hclk    (hclk),
		.hresetn (hresetn),
		.w       (xw.gen)
	);

	assign pw.busy      = (pri_st == debi_pkg::PS_RACT) || (pri_st == debi_pkg::PS_WACT);
	assign pw.mode      = cfg.pri_mode;
	assign pw.count     = cfg.pri_cnt;
	assign pw.ext_rdy_n = pri_rdy_n;
	assign xw.busy      = (exp_st == debi_pkg::XS_RACT) || (exp_st == debi_pkg::XS_WACT)
		|| (exp_st == debi_pkg::XS_IOACT);
	assign xw.mode      = cfg.exp_mode;
	assign xw.count     = cfg.exp_cnt;
	assign xw.ext_rdy_n = expansion_ready_input_n;
	assign cfg.hold_status = !bus_release_grant_n;

	// Release request is asynchronous; only the second flop is used
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hold_meta <= 1'b1;
			hold_sync <= 1'b1;
		end
		else
		begin
			hold_meta <= hold_req_n;
			hold_sync <= hold_meta;
		end
	end

	assign hold_want = cfg.software_bus_release || (!hold_sync && !cfg.ignore_release_request);

	assign mask        = bank_mask(cfg.bank_cmp);
	assign bank_switch = !pri_we && (cfg.bank_cmp != 5'h0) && ((pri_addr & mask) != (bank_bits & mask));

	// Back-to-back takes keep reads at one cycle and writes at two
	assign pri_take = pri_req && !hold_want && ((pri_st == debi_pkg::PS_IDLE) || (pri_st == debi_pkg::PS_WPOST)
		|| (pri_st == debi_pkg::PS_RACT && !pw.int_rdy_n));
	assign exp_take = exp_req && ((exp_st == debi_pkg::XS_IDLE) || (exp_st == debi_pkg::XS_WPOST)
		|| (exp_st == debi_pkg::XS_RACT && !xw.int_rdy_n) || (exp_st == debi_pkg::XS_IOACT && !xw.int_rdy_n));

	// Primary bus sequencer; one state per whole bus cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pri_st                  <= debi_pkg::PS_IDLE;
			primary_access_strobe_n <= 1'b1;
			pri_rnw                 <= 1'b1;
			pri_addr_o              <= 24'h0;
			pri_ctl_oe              <= 1'b1;
			pri_data_o              <= 32'h0;
			pri_data_oe             <= 1'b0;
			bus_release_grant_n     <= 1'b1;
			pri_ack                 <= 1'b0;
		end
		else
		begin
			pri_ack <= 1'b0;
			if (pri_take)
			begin
				pri_ack    <= 1'b1;
				pri_addr_o <= pri_addr;
				if (pri_we)
				begin
					pri_data_o <= pri_wdata;
					if (pri_rnw)
					begin
						pri_st                  <= debi_pkg::PS_WTURN;
						primary_access_strobe_n <= 1'b1;
						pri_rnw                 <= 1'b0;
						pri_data_oe             <= 1'b0;
					end
					else
					begin
						pri_st                  <= debi_pkg::PS_WACT;
						primary_access_strobe_n <= 1'b0;
						pri_data_oe             <= 1'b1;
					end
				end
				else
				begin
					pri_rnw     <= 1'b1;
					pri_data_oe <= 1'b0;
					if (bank_switch)
					begin
						pri_st                  <= debi_pkg::PS_BANK;
						primary_access_strobe_n <= 1'b1;
					end
					else
					begin
						pri_st                  <= debi_pkg::PS_RACT;
						primary_access_strobe_n <= 1'b0;
					end
				end
			end
			else
			begin
				case (pri_st)
					debi_pkg::PS_IDLE:
					begin
						primary_access_strobe_n <= 1'b1;
						pri_rnw                 <= 1'b1;
						if (hold_want)
						begin
							pri_st              <= debi_pkg::PS_HOLD;
							pri_ctl_oe          <= 1'b0;
							pri_data_oe         <= 1'b0;
							bus_release_grant_n <= 1'b0;
						end
					end
					debi_pkg::PS_BANK:
					begin
						pri_st                  <= debi_pkg::PS_RACT;
						primary_access_strobe_n <= 1'b0;
					end
					debi_pkg::PS_RACT:
						if (!pw.int_rdy_n)
						begin
							pri_st                  <= debi_pkg::PS_IDLE;
							primary_access_strobe_n <= 1'b1;
						end
					debi_pkg::PS_WTURN:
					begin
						pri_st                  <= debi_pkg::PS_WACT;
						primary_access_strobe_n <= 1'b0;
						pri_data_oe             <= 1'b1;
					end
					debi_pkg::PS_WACT:
						if (!pw.int_rdy_n)
						begin
							pri_st                  <= debi_pkg::PS_WPOST;
							primary_access_strobe_n <= 1'b1;
						end
					debi_pkg::PS_WPOST:
					begin
						pri_st      <= debi_pkg::PS_IDLE;
						pri_data_oe <= 1'b0;
					end
					default:
						if (!hold_want)
						begin
							pri_st              <= debi_pkg::PS_IDLE;
							pri_ctl_oe          <= 1'b1;
							bus_release_grant_n <= 1'b1;
						end
				endcase
			end
		end
	end

	// Bank bits follow every primary access
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			bank_bits <= 24'h0;
		else if (pri_take)
			bank_bits <= pri_addr & mask;
	end

	// Read data is taken in the completing cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pri_rvalid <= 1'b0;
			pri_rdata  <= 32'h0;
			exp_rvalid <= 1'b0;
			exp_rdata  <= 32'h0;
		end
		else
		begin
			pri_rvalid <= (pri_st == debi_pkg::PS_RACT) && !pw.int_rdy_n;
			if ((pri_st == debi_pkg::PS_RACT) && !pw.int_rdy_n)
				pri_rdata <= pri_data_i;
			exp_rvalid <= ((exp_st == debi_pkg::XS_RACT) || (exp_st == debi_pkg::XS_IOACT && expansion_read_not_write))
				&& !xw.int_rdy_n;
			if (((exp_st == debi_pkg::XS_RACT) || (exp_st == debi_pkg::XS_IOACT)) && !xw.int_rdy_n)
				exp_rdata <= exp_data_i;
		end
	end

	// Expansion bus sequencer; never inserts bank cycles
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			exp_st                    <= debi_pkg::XS_IDLE;
			expansion_memory_strobe_n <= 1'b1;
			expansion_io_strobe_n     <= 1'b1;
			expansion_read_not_write  <= 1'b1;
			expansion_address_bus     <= 13'h0;
			exp_data_o                <= 32'h0;
			exp_data_oe               <= 1'b0;
			exp_ack                   <= 1'b0;
		end
		else
		begin
			exp_ack <= 1'b0;
			if (exp_take)
			begin
				exp_ack                   <= 1'b1;
				expansion_address_bus     <= exp_addr;
				expansion_memory_strobe_n <= 1'b1;
				expansion_io_strobe_n     <= 1'b1;
				exp_data_o                <= exp_wdata;
				if (exp_io)
				begin
					exp_st                   <= debi_pkg::XS_IOSET;
					expansion_read_not_write <= !exp_we;
					exp_data_oe              <= exp_we;
				end
				else if (exp_we && expansion_read_not_write)
				begin
					exp_st                   <= debi_pkg::XS_WTURN;
					expansion_read_not_write <= 1'b0;
					exp_data_oe              <= 1'b0;
				end
				else if (exp_we)
				begin
					exp_st                    <= debi_pkg::XS_WACT;
					expansion_memory_strobe_n <= 1'b0;
					exp_data_oe               <= 1'b1;
				end
				else
				begin
					exp_st                    <= debi_pkg::XS_RACT;
					expansion_memory_strobe_n <= 1'b0;
					expansion_read_not_write  <= 1'b1;
					exp_data_oe               <= 1'b0;
				end
			end
			else
			begin
				case (exp_st)
					debi_pkg::XS_RACT:
						if (!xw.int_rdy_n)
						begin
							exp_st                    <= debi_pkg::XS_IDLE;
							expansion_memory_strobe_n <= 1'b1;
						end
					debi_pkg::XS_WTURN:
					begin
						exp_st                    <= debi_pkg::XS_WACT;
						expansion_memory_strobe_n <= 1'b0;
						exp_data_oe               <= 1'b1;
					end
					debi_pkg::XS_WACT:
						if (!xw.int_rdy_n)
						begin
							exp_st                    <= debi_pkg::XS_WPOST;
							expansion_memory_strobe_n <= 1'b1;
						end
					debi_pkg::XS_IOSET:
					begin
						exp_st                <= debi_pkg::XS_IOACT;
						expansion_io_strobe_n <= 1'b0;
					end
					debi_pkg::XS_IOACT:
						if (!xw.int_rdy_n)
						begin
							exp_st                <= debi_pkg::XS_IDLE;
							expansion_io_strobe_n <= 1'b1;
						end
					debi_pkg::XS_WPOST:
					begin
						exp_st      <= debi_pkg::XS_IDLE;
						exp_data_oe <= 1'b0;
					end
					default:
					begin
						expansion_memory_strobe_n <= 1'b1;
						expansion_io_strobe_n     <= 1'b1;
						expansion_read_not_write  <= 1'b1;
						exp_data_oe               <= 1'b0;
					end
				endcase
			end
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_bank_gap;
		pri_st == debi_pkg::PS_BANK && primary_access_strobe_n;
	endsequence

	sequence s_io_setup;
		exp_st == debi_pkg::XS_IOSET && expansion_io_strobe_n;
	endsequence

	excl_strobe_a: assert property (!(!expansion_memory_strobe_n && !expansion_io_strobe_n))
		else $error("expansion strobes low together");
	rw_stable_a: assert property (!primary_access_strobe_n && !$past(primary_access_strobe_n) |-> $stable(pri_rnw))
		else $error("primary direction changed under strobe");
	wait_hold_a: assert property ((pri_st == debi_pkg::PS_RACT && pw.int_rdy_n) |=>
		(pri_st == debi_pkg::PS_RACT && !primary_access_strobe_n && $stable(pri_addr_o)))
		else $error("wait state did not hold access");
	bank_gap_a: assert property (s_bank_gap |=> pri_st == debi_pkg::PS_RACT && !primary_access_strobe_n)
		else $error("bank idle cycle not followed by read");
	io_cycle_a: assert property (s_io_setup |=> !expansion_io_strobe_n ##0 $stable(expansion_address_bus))
		else $error("io strobe not framed by address");
	grant_float_a: assert property (!bus_release_grant_n |-> !pri_ctl_oe && !pri_data_oe)
		else $error("bus driven while release granted");
	grant_idle_a: assert property ($fell(bus_release_grant_n) |-> $past(pri_st) == debi_pkg::PS_IDLE)
		else $error("release granted during access");
	idle_high_a: assert property (pri_st == debi_pkg::PS_IDLE && $past(pri_st) == debi_pkg::PS_IDLE
		|-> primary_access_strobe_n && pri_rnw)
		else $error("idle primary bus not high");
	write_turn_a: assert property (pri_st == debi_pkg::PS_WTURN |=> pri_st == debi_pkg::PS_WACT ##1
		pri_st != debi_pkg::PS_WTURN)
		else $error("write turn sequence broken");
	io_rw_a: assert property (!expansion_io_strobe_n |-> $stable(expansion_read_not_write))
		else $error("io direction changed under strobe");

endmodule : debi_top

// ### dv/debi_mem_model.sv
`timescale 1ns/10ps

module debi_mem_model #(
	parameter int AW = 24
) (
	// Bus side
	input  wire logic          hclk,
	input  wire logic          strobe_n,
	input  wire logic          rnw,
	input  wire logic [AW-1:0] addr,
	input  wire logic          slow,
	output logic [31:0]        data_i,
	output logic               rdy_n
);
	logic [31:0] spin = 32'h0;
	logic        prev_n = 1'b1;
	always_ff @(posedge hclk)
	begin
		spin   <= spin + 32'h1;
		prev_n <= strobe_n;
	end
	// Released data lines show a moving pattern, so stale read data is never mistaken for valid
	assign data_i = (!strobe_n && rnw) ? (32'h5A000000 ^ 32'(addr)) : ~spin;
	// Slow device holds ready off for the first strobe cycle; idle ready toggles as it is ignored
	assign rdy_n = strobe_n ? spin[0] : (slow & prev_n);
endmodule : debi_mem_model

// ### dv/tb.sv
`timescale 1ns/10ps
`include "debi_defines.svh"

module tb;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic        pri_req = 1'b0;
	logic        pri_we = 1'b0;
	logic        exp_req = 1'b0;
	logic        exp_we = 1'b0;
	logic        exp_io = 1'b0;
	logic        slow = 1'b0;
	logic        x = 1'b0;
	logic        hold_req_n = 1'b1;
	logic [23:0] pri_addr = 24'h0;
	logic [12:0] exp_addr = 13'h0;
	logic [31:0] wdata = 32'hC3A50F1E;
	logic        hreadyout, hresp, pri_ack, pri_rvalid, exp_ack, exp_rvalid, pri_ctl_oe, pri_data_oe;
	logic        primary_access_strobe_n, pri_rnw, bus_release_grant_n, exp_data_oe, pri_rdy_n;
	logic        expansion_memory_strobe_n, expansion_io_strobe_n, expansion_read_not_write, expansion_ready_input_n;
	logic [31:0] hrdata, pri_rdata, exp_rdata, pri_data_o, exp_data_o, pri_data_i, exp_data_i, r;
	logic [23:0] pri_addr_o;
	logic [12:0] expansion_address_bus;
	int          miscompares = 0;
	int          compares = 0;
	int          i;
	wire         ack = x ? exp_ack : pri_ack;
	wire         rv = x ? exp_rvalid : pri_rvalid;
	wire         xs_n = expansion_memory_strobe_n & expansion_io_strobe_n;
	wire         stb_n = x ? xs_n : primary_access_strobe_n;
	wire         rnw = x ? expansion_read_not_write : pri_rnw;
	wire [31:0]  rd = x ? exp_rdata : pri_rdata;
	wire [31:0]  wd = x ? exp_data_o : pri_data_o;
	wire         doe = x ? exp_data_oe : pri_data_oe;

	debi_top dut (.*, .hready(hreadyout), .hsize(3'h2), .pri_wdata(wdata), .exp_wdata(wdata));
	debi_mem_model #(.AW(24)) pri_mem (.hclk(hclk), .strobe_n(primary_access_strobe_n), .rnw(pri_rnw),
		.addr(pri_addr_o), .slow(slow), .data_i(pri_data_i), .rdy_n(pri_rdy_n));
	debi_mem_model #(.AW(13)) exp_mem (.hclk(hclk), .strobe_n(xs_n), .rnw(expansion_read_not_write),
		.addr(expansion_address_bus), .slow(slow), .data_i(exp_data_i), .rdy_n(expansion_ready_input_n));

	always #20 hclk = ~hclk;

	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : ahb

	// One access on either bus: strobe-low cycles counted, acknowledge-to-data latency checked
	task op(input logic bx, input logic io, input logic we, input logic [23:0] a, input int lo, input int lat);
		int n;
		int l;
		n = 0;
		l = 0;
		@(posedge hclk);
		x <= bx;
		exp_io <= io;
		pri_req <= !bx;
		exp_req <= bx;
		pri_we <= we;
		exp_we <= we;
		pri_addr <= a;
		exp_addr <= a[12:0];
		do @(negedge hclk); while (ack !== 1'b1);
		pri_req <= 1'b0;
		exp_req <= 1'b0;
		repeat (12)
		begin
			if (stb_n === 1'b0)
			begin
				n++;
				chk("rnw", !we, rnw);
				if (we) chk("wdata", wdata, wd);
				if (we) chk("data oe", 1'b1, doe);
			end
			if (rv === 1'b1) chk("lat", lat, l);
			if (rv === 1'b1) chk("rdata", 32'h5A000000 ^ (bx ? {19'h0, a[12:0]} : {8'h0, a}), rd);
			l++;
			@(negedge hclk);
		end
		chk("strobe", lo, n);
		chk("idle", 5'h1F, {primary_access_strobe_n, pri_rnw, xs_n, expansion_read_not_write, 1'b1});
	endtask : op

	task wt(input logic [1:0] m, input logic [2:0] c, input logic s, input int lo);
		ahb(1'b1, `DEBI_PRI_CTL_ADDR, {24'h0, c, m, 3'h0});
		slow <= s;
		op(1'b0, 1'b0, 1'b0, 24'h000040, lo, lo);
	endtask : wt

	task wg(input logic v);
		i = 0;
		do @(negedge hclk); while (bus_release_grant_n !== v && ++i < 20);
		chk("grant", v, bus_release_grant_n);
	endtask : wg

	task test_done;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	initial
	begin
		#400000;
		miscompares++;
		test_done();
	end

	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, `DEBI_EXP_CTL_ADDR, 32'h0);
		chk("exp ctl", 32'h000000F8, r);
		ahb(1'b0, `DEBI_PRI_CTL_ADDR, 32'h0);
		chk("pri ctl", 32'h000010F8, r);
		ahb(1'b0, 32'h00808068, 32'h0);
		chk("unmapped", 32'h0, r);
		$display("register test done");
		wt(2'h0, 3'h3, 1'b1, 2);
		wt(2'h1, 3'h3, 1'b1, 4);
		wt(2'h2, 3'h3, 1'b1, 2);
		wt(2'h3, 3'h3, 1'b1, 4);
		wt(2'h1, 3'h0, 1'b0, 1);
		op(1'b0, 1'b0, 1'b1, 24'h000044, 1, 0);
		$display("wait test done");
		ahb(1'b1, `DEBI_PRI_CTL_ADDR, 32'h00001008);
		op(1'b0, 1'b0, 1'b0, 24'h123400, 1, 2);
		op(1'b0, 1'b0, 1'b0, 24'h1234FF, 1, 1);
		op(1'b0, 1'b0, 1'b1, 24'h560000, 1, 0);
		op(1'b0, 1'b0, 1'b0, 24'h560010, 1, 1);
		ahb(1'b1, `DEBI_PRI_CTL_ADDR, 32'h00000008);
		op(1'b0, 1'b0, 1'b0, 24'hFF0000, 1, 1);
		$display("bank test done");
		ahb(1'b1, `DEBI_EXP_CTL_ADDR, 32'h00000008);
		op(1'b1, 1'b1, 1'b0, 24'h000123, 1, 2);
		op(1'b1, 1'b1, 1'b1, 24'h000456, 1, 0);
		op(1'b1, 1'b0, 1'b0, 24'h001ABC, 1, 1);
		op(1'b1, 1'b0, 1'b1, 24'h000789, 1, 0);
		$display("expansion test done");
		@(posedge hclk);
		hold_req_n <= 1'b0;
		wg(1'b0);
		chk("delay", 1'b1, i >= 3);
		chk("ctl oe", 1'b0, pri_ctl_oe);
		hold_req_n <= 1'b1;
		wg(1'b1);
		ahb(1'b1, `DEBI_PRI_CTL_ADDR, 32'h00000002);
		hold_req_n <= 1'b0;
		repeat (10) @(negedge hclk);
		chk("ignored", 1'b1, bus_release_grant_n);
		hold_req_n <= 1'b1;
		ahb(1'b1, `DEBI_PRI_CTL_ADDR, 32'h00000004);
		wg(1'b0);
		ahb(1'b0, `DEBI_PRI_CTL_ADDR, 32'h0);
		chk("hold status", 32'h00000005, r);
		ahb(1'b1, `DEBI_PRI_CTL_ADDR, 32'h0);
		wg(1'b1);
		$display("release test done");
		test_done();
	end
endmodule : tb
